// File: common/hpc_pkg.sv
// Shared constants for the host port cycle handshake
package hpc_pkg;
    // Port and word widths
    localparam int HPC_HALF_W = 16;
    localparam int HPC_WORD_W = 32;

    // Register select codes
    localparam logic [1:0] HPC_SEL_CTRL      = 2'h0;
    localparam logic [1:0] HPC_SEL_DATA_INC  = 2'h1;
    localparam logic [1:0] HPC_SEL_ADDR      = 2'h2;
    localparam logic [1:0] HPC_SEL_DATA      = 2'h3;

    // Halfword select and read/write select levels
    localparam logic HPC_HALF_FIRST = 1'h0;
    localparam logic HPC_RW_READ    = 1'h1;

    // Control register fields
    localparam int HPC_CTRL_ORDER_BIT = 0;
    localparam int HPC_CTRL_BUSY_BIT  = 3;

    // Reset values
    localparam logic [HPC_HALF_W-1:0] HPC_CTRL_RST = 16'h0000;
    localparam logic [HPC_WORD_W-1:0] HPC_WORD_RST = 32'h0000_0000;

    // Address advance per autoincrement, in bytes
    localparam logic [HPC_WORD_W-1:0] HPC_ADDR_STEP = 32'h0000_0004;

    // Work engine states
    typedef enum logic [1:0] {
        HPC_ST_IDLE  = 2'h0,
        HPC_ST_FETCH = 2'h1,
        HPC_ST_STORE = 2'h2,
        HPC_ST_STEP  = 2'h3
    } hpc_state_t;
endpackage

// File: hw/hpc_strobe_capture.sv
`timescale 1ns/10ps
`default_nettype none
module hpc_strobe_capture
    import hpc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       data_strobe_a,
    input  wire logic       data_strobe_b,
    input  wire logic       port_chip_select_n,
    input  wire logic       addr_latch_n,
    input  wire logic [1:0] register_select,
    input  wire logic       read_write_select,
    input  wire logic       halfword_select,
    output logic            strobe_fall,
    output logic            strobe_rise,
    output logic            strobe_low,
    output logic [1:0]      sel_eff,
    output logic            rw_eff,
    output logic            half_eff
);
    logic       access_strobe_n;
    logic       strobe_prev_r;
    logic       latch_prev_r;
    logic       capture;
    logic [1:0] reg_sel_r;
    logic       rw_r;
    logic       half_r;
    logic [1:0] reg_sel_nxt;
    logic       rw_nxt;
    logic       half_nxt;
    logic       latch_fall;

    // Composite strobe, active low
    assign access_strobe_n = ~(data_strobe_a ^ data_strobe_b) | port_chip_select_n;
    assign strobe_fall     = strobe_prev_r & ~access_strobe_n;
    assign strobe_rise     = ~strobe_prev_r & access_strobe_n;
    assign strobe_low      = ~access_strobe_n;
    assign latch_fall      = latch_prev_r & ~addr_latch_n;

    // Address strobe edge captures when used; a high level at strobe fall means it is tied off
    assign capture = latch_fall | (strobe_fall & addr_latch_n);

    // Selects are usable in the capture cycle itself, then held
    always_comb begin
        reg_sel_nxt = capture ? register_select   : reg_sel_r;
        rw_nxt      = capture ? read_write_select : rw_r;
        half_nxt    = capture ? halfword_select   : half_r;
    end
    assign sel_eff  = reg_sel_nxt;
    assign rw_eff   = rw_nxt;
    assign half_eff = half_nxt;

    // Edge history and held selects
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            strobe_prev_r <= 1'h1;
            latch_prev_r  <= 1'h1;
            reg_sel_r     <= HPC_SEL_CTRL;
            rw_r          <= HPC_RW_READ;
            half_r        <= HPC_HALF_FIRST;
        end else begin
            strobe_prev_r <= access_strobe_n;
            latch_prev_r  <= addr_latch_n;
            reg_sel_r     <= reg_sel_nxt;
            rw_r          <= rw_nxt;
            half_r        <= half_nxt;
        end
    end

    a_strobe_form: assert property (@(posedge sys_clk) disable iff (sys_rst)
        strobe_fall |-> !port_chip_select_n && (data_strobe_a != data_strobe_b))
        else $error("strobe fell without chip select and one active data strobe");

    a_select_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (strobe_fall && addr_latch_n) |=> reg_sel_r == $past(register_select)
            && rw_r == $past(read_write_select) && half_r == $past(halfword_select))
        else $error("selects not captured at strobe fall");

    a_latch_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
        latch_fall |=> reg_sel_r == $past(register_select)
            && rw_r == $past(read_write_select) && half_r == $past(halfword_select))
        else $error("selects not captured at address strobe fall");
endmodule // hpc_strobe_capture
`default_nettype wire

// File: hw/hpc_host_port.sv
`timescale 1ns/10ps
`default_nettype none
module hpc_host_port
    import hpc_pkg::*;
#(
    parameter int HALF_W = HPC_HALF_W,
    parameter int WORD_W = HPC_WORD_W
)(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              data_strobe_a,
    input  wire logic              data_strobe_b,
    input  wire logic              port_chip_select_n,
    input  wire logic              addr_latch_n,
    input  wire logic [1:0]        register_select,
    input  wire logic              read_write_select,
    input  wire logic              halfword_select,
    input  wire logic [HALF_W-1:0] host_data_in,
    output logic      [HALF_W-1:0] host_data_out,
    output logic                   host_data_oe_n,
    output logic                   port_ready_n,
    output logic                   dma_req,
    output logic                   dma_write,
    output logic      [WORD_W-1:0] dma_addr,
    output logic      [WORD_W-1:0] dma_wdata,
    input  wire logic              dma_ack,
    input  wire logic [WORD_W-1:0] dma_rdata
);
    // Both word registers are built from exactly two host halfwords
    if (HALF_W != HPC_HALF_W || WORD_W != 2 * HALF_W) begin : g_width_check
        $error("hpc_host_port serves only a 16-bit port and 32-bit words");
    end

    logic              strobe_fall;
    logic              strobe_rise;
    logic              strobe_low;
    logic [1:0]        sel;
    logic              rw;
    logic              half;
    logic              is_data;
    logic              is_read;

    hpc_state_t        state_r, state_nxt;
    logic [HALF_W-1:0] ctrl_r, ctrl_nxt;
    logic [WORD_W-1:0] addr_r, addr_nxt;
    logic [WORD_W-1:0] data_r, data_nxt;
    logic              fetch_pend_r, fetch_pend_nxt;
    logic              store_pend_r, store_pend_nxt;
    logic              step_pend_r, step_pend_nxt;
    logic              inc_after_r, inc_after_nxt;
    logic              busy_nxt;
    logic [HALF_W-1:0] dout_r, dout_nxt;
    logic              oe_n_r, oe_n_nxt;
    logic              ready_n_r, ready_n_nxt;
    logic              req_r, req_nxt;
    logic              wr_r, wr_nxt;

    // Strobe forming and select capture
    hpc_strobe_capture u_capture (
        .sys_clk            (sys_clk),
        .sys_rst            (sys_rst),
        .data_strobe_a      (data_strobe_a),
        .data_strobe_b      (data_strobe_b),
        .port_chip_select_n (port_chip_select_n),
        .addr_latch_n       (addr_latch_n),
        .register_select    (register_select),
        .read_write_select  (read_write_select),
        .halfword_select    (halfword_select),
        .strobe_fall        (strobe_fall),
        .strobe_rise        (strobe_rise),
        .strobe_low         (strobe_low),
        .sel_eff            (sel),
        .rw_eff             (rw),
        .half_eff           (half)
    );

    // Pick the halfword the host addresses; order bit set puts the high half first
    function automatic logic [HPC_HALF_W-1:0] get_half(input logic [HPC_WORD_W-1:0] w,
                                                     input logic h, input logic order);
        get_half = ((h == HPC_HALF_FIRST) == order) ? w[HPC_WORD_W-1:HPC_HALF_W]
                                                     : w[HPC_HALF_W-1:0];
    endfunction

    function automatic logic [HPC_WORD_W-1:0] put_half(input logic [HPC_WORD_W-1:0] w,
                                                     input logic [HPC_HALF_W-1:0] d,
                                                     input logic h, input logic order);
        put_half = ((h == HPC_HALF_FIRST) == order) ? {d, w[HPC_HALF_W-1:0]}
                                                     : {w[HPC_WORD_W-1:HPC_HALF_W], d};
    endfunction

    assign is_data = (sel == HPC_SEL_DATA) || (sel == HPC_SEL_DATA_INC);
    assign is_read = (rw == HPC_RW_READ);

    // Work engine, register file, and pin outputs
    always_comb begin
        state_nxt      = state_r;
        ctrl_nxt       = ctrl_r;
        addr_nxt       = addr_r;
        data_nxt       = data_r;
        fetch_pend_nxt = fetch_pend_r;
        store_pend_nxt = store_pend_r;
        step_pend_nxt  = step_pend_r;
        inc_after_nxt  = inc_after_r;
        req_nxt        = req_r;
        wr_nxt         = wr_r;
        dout_nxt       = dout_r;

        // Engine: a fetch outranks a store so the host read waits least
        case (state_r)
            HPC_ST_IDLE: begin
                if (fetch_pend_r) begin
                    fetch_pend_nxt = 1'h0;
                    req_nxt        = 1'h1;
                    wr_nxt         = 1'h0;
                    state_nxt      = HPC_ST_FETCH;
                end else if (store_pend_r) begin
                    store_pend_nxt = 1'h0;
                    req_nxt        = 1'h1;
                    wr_nxt         = 1'h1;
                    state_nxt      = HPC_ST_STORE;
                end else if (step_pend_r) begin
                    step_pend_nxt = 1'h0;
                    addr_nxt      = addr_r + HPC_ADDR_STEP;
                    state_nxt     = HPC_ST_STEP;
                end
            end
            HPC_ST_FETCH: begin
                if (dma_ack) begin
                    data_nxt  = dma_rdata;
                    req_nxt   = 1'h0;
                    state_nxt = HPC_ST_IDLE;
                end
            end
            HPC_ST_STORE: begin
                if (dma_ack) begin
                    req_nxt   = 1'h0;
                    addr_nxt  = inc_after_r ? addr_r + HPC_ADDR_STEP : addr_r;
                    state_nxt = HPC_ST_IDLE;
                end
            end
            HPC_ST_STEP: begin
                state_nxt = HPC_ST_IDLE;
            end
            default: begin
                state_nxt = HPC_ST_IDLE;
            end
        endcase

        // Host events come after the engine so a new request is never lost
        if (strobe_fall && is_read && is_data && half == HPC_HALF_FIRST) begin
            fetch_pend_nxt = 1'h1;
        end
        if (strobe_rise && !is_read) begin
            case (sel)
                HPC_SEL_CTRL: ctrl_nxt = host_data_in;
                HPC_SEL_ADDR: addr_nxt = put_half(addr_r, host_data_in, half,
                                                  ctrl_r[HPC_CTRL_ORDER_BIT]);
                default:      data_nxt = put_half(data_r, host_data_in, half,
                                                  ctrl_r[HPC_CTRL_ORDER_BIT]);
            endcase
            if (is_data && half != HPC_HALF_FIRST) begin
                store_pend_nxt = 1'h1;
                inc_after_nxt  = (sel == HPC_SEL_DATA_INC);
            end
        end
        if (strobe_rise && is_read && sel == HPC_SEL_DATA_INC && half != HPC_HALF_FIRST) begin
            step_pend_nxt = 1'h1;
        end

        // Only data work counts as busy, so control and address cycles leave ready low
        busy_nxt = (state_nxt != HPC_ST_IDLE) || fetch_pend_nxt
                   || store_pend_nxt || step_pend_nxt;
        // Chip select gates ready; busy shows as soon as select falls
        ready_n_nxt = port_chip_select_n ? 1'h0 : busy_nxt;

        // Drive only in reads while the strobe is low
        oe_n_nxt = !(strobe_low && is_read);
        case (sel)
            HPC_SEL_CTRL: begin
                dout_nxt = ctrl_r;
                dout_nxt[HPC_CTRL_BUSY_BIT] = busy_nxt;
            end
            HPC_SEL_ADDR: dout_nxt = get_half(addr_r, half, ctrl_r[HPC_CTRL_ORDER_BIT]);
            default:      dout_nxt = get_half(data_r, half, ctrl_r[HPC_CTRL_ORDER_BIT]);
        endcase
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_r      <= HPC_ST_IDLE;
            ctrl_r       <= HPC_CTRL_RST;
            addr_r       <= HPC_WORD_RST;
            data_r       <= HPC_WORD_RST;
            fetch_pend_r <= 1'h0;
            store_pend_r <= 1'h0;
            step_pend_r  <= 1'h0;
            inc_after_r  <= 1'h0;
            req_r        <= 1'h0;
            wr_r         <= 1'h0;
            dout_r       <= '0;
            oe_n_r       <= 1'h1;
            ready_n_r    <= 1'h0;
        end else begin
            state_r      <= state_nxt;
            ctrl_r       <= ctrl_nxt;
            addr_r       <= addr_nxt;
            data_r       <= data_nxt;
            fetch_pend_r <= fetch_pend_nxt;
            store_pend_r <= store_pend_nxt;
            step_pend_r  <= step_pend_nxt;
            inc_after_r  <= inc_after_nxt;
            req_r        <= req_nxt;
            wr_r         <= wr_nxt;
            dout_r       <= dout_nxt;
            oe_n_r       <= oe_n_nxt;
            ready_n_r    <= ready_n_nxt;
        end
    end

    // Address and store data are stable while a request is held
    assign host_data_out  = dout_r;
    assign host_data_oe_n = oe_n_r;
    assign port_ready_n   = ready_n_r;
    assign dma_req        = req_r;
    assign dma_write      = wr_r;
    assign dma_addr       = addr_r;
    assign dma_wdata      = data_r;

    a_ready_cs_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
        port_chip_select_n |=> !port_ready_n)
        else $error("ready not low while chip select high");

    a_busy_cs_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ($fell(port_chip_select_n) && (state_r == HPC_ST_FETCH || state_r == HPC_ST_STORE)
         && !dma_ack) |=> port_ready_n)
        else $error("ready not high at select fall during pending work");

    a_fetch_request: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (strobe_fall && is_read && is_data && half == HPC_HALF_FIRST && state_r == HPC_ST_IDLE
         && !store_pend_r && !step_pend_r && !fetch_pend_r) |=> ##1 (dma_req && !dma_write))
        else $error("data read did not request a fetch two cycles later");

    a_fetch_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == HPC_ST_FETCH && !dma_ack && !port_chip_select_n) |=> port_ready_n)
        else $error("ready dropped while fetch still open");

    a_fetch_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_r == HPC_ST_FETCH && dma_ack) |=> (data_r == $past(dma_rdata)) && !dma_req)
        else $error("fetched word not loaded");

    a_ctrl_no_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (strobe_rise && !is_data && state_r == HPC_ST_IDLE && !fetch_pend_r && !store_pend_r
         && !step_pend_r) |=> !port_ready_n)
        else $error("control or address access changed ready");

    a_write_busy: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (strobe_rise && !is_read && is_data && half != HPC_HALF_FIRST && !port_chip_select_n)
        |=> port_ready_n ##1 (dma_req && dma_write) [*1])
        else $error("second write half did not start busy store");

    a_read_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (strobe_low && is_read) |=> !host_data_oe_n)
        else $error("data bus not driven during read");

    a_write_float: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (!strobe_low || !is_read) |=> host_data_oe_n)
        else $error("data bus driven outside a read");
endmodule // hpc_host_port
`default_nettype wire

// File: bench/hpc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module hpc_host_model
    import hpc_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  port_ready_n,
    input  wire logic                  host_data_oe_n,
    input  wire logic [HPC_HALF_W-1:0] host_data_out,
    output logic                       data_strobe_a,
    output logic                       data_strobe_b,
    output logic                       port_chip_select_n,
    output logic                       addr_latch_n,
    output logic [1:0]                 register_select,
    output logic                       read_write_select,
    output logic                       halfword_select,
    output logic [HPC_HALF_W-1:0]      host_data_in
);
    // Samples left for the bench after each access
    logic [HPC_HALF_W-1:0] rd_val;
    logic                  busy_cs, busy_mid, oe_mid, rdy_after, oe_end, rdy_end, hung;

    // Idle bus: deselected, strobe lines equal so the strobe is inactive
    initial begin
        {data_strobe_a, data_strobe_b} = 2'h0;
        port_chip_select_n = 1'b1;
        addr_latch_n = 1'b1;
        {register_select, read_write_select, halfword_select} = 4'h0;
        host_data_in = 16'h0000;
        hung = 1'b0;
    end

    // Strobe line pulse while deselected; the port must ignore it
    task automatic ghost();
        @(negedge sys_clk);
        data_strobe_a = ~data_strobe_b; // Gated off by chip select
        repeat (3) @(negedge sys_clk);
        oe_mid = host_data_oe_n;
        busy_mid = port_ready_n;
        data_strobe_a = data_strobe_b;
    endtask

    // One half-word cycle; released lines show inverted garbage, not old values
    task automatic access(input logic [1:0] sel, input logic rw, input logic half,
                          input logic use_as, input logic keep_cs, input logic which,
                          input logic [HPC_HALF_W-1:0] wd);
        int n;
        n = 0;
        @(negedge sys_clk);
        port_chip_select_n = 1'b0;
        register_select = sel;
        read_write_select = rw;
        halfword_select = half;
        addr_latch_n = ~use_as; // Address strobe low ahead of the access strobe
        @(negedge sys_clk);
        busy_cs = port_ready_n;
        if (use_as) begin
            {register_select, read_write_select, halfword_select} = ~{sel, rw, half};
        end
        host_data_in = rw ? ~wd : wd;
        if (which) data_strobe_a = ~data_strobe_b; // Either line may open the strobe
        else data_strobe_b = ~data_strobe_a;
        repeat (2) @(negedge sys_clk); // Low for two periods at least
        busy_mid = port_ready_n;
        while (port_ready_n !== 1'b0 && n < 400) begin // Hold until ready
            @(negedge sys_clk);
            n++;
        end
        if (n >= 400) hung = 1'b1;
        @(negedge sys_clk);
        rd_val = host_data_out;
        oe_mid = host_data_oe_n;
        data_strobe_a = data_strobe_b; // Write data still valid here
        @(negedge sys_clk);
        if (!keep_cs) port_chip_select_n = 1'b1;
        addr_latch_n = 1'b1; // Raised each access so the next latch edge is seen
        {register_select, read_write_select, halfword_select} = ~{sel, rw, half};
        host_data_in = ~host_data_in;
        @(negedge sys_clk);
        rdy_after = port_ready_n;
        @(negedge sys_clk); // High for three periods at least before the next
        oe_end = host_data_oe_n;
        rdy_end = port_ready_n;
    endtask
endmodule // hpc_host_model
`default_nettype wire

// File: bench/tb_hpc_host_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_hpc_host_port
    import hpc_pkg::*;
;
    logic                  sys_clk, sys_rst, dma_ack, dma_req, dma_write, order, use_as;
    logic                  data_strobe_a, data_strobe_b, port_chip_select_n, addr_latch_n;
    logic                  read_write_select, halfword_select, host_data_oe_n, port_ready_n;
    logic [1:0]            register_select;
    logic [HPC_HALF_W-1:0] host_data_in, host_data_out;
    logic [HPC_WORD_W-1:0] dma_addr, dma_wdata, dma_rdata, a, x, y;
    logic [HPC_WORD_W-1:0] mem [logic [HPC_WORD_W-1:0]];
    int                    errors, checks_done, cycles, dma_lat, wait_cnt, seed;

    // Free-running 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    hpc_host_port hpc_host_port_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .data_strobe_a(data_strobe_a), .data_strobe_b(data_strobe_b),
        .port_chip_select_n(port_chip_select_n), .addr_latch_n(addr_latch_n),
        .register_select(register_select), .read_write_select(read_write_select),
        .halfword_select(halfword_select), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe_n(host_data_oe_n),
        .port_ready_n(port_ready_n), .dma_req(dma_req), .dma_write(dma_write),
        .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack), .dma_rdata(dma_rdata));

    hpc_host_model hpc_host_model_inst (.sys_clk(sys_clk), .port_ready_n(port_ready_n),
        .host_data_oe_n(host_data_oe_n), .host_data_out(host_data_out),
        .data_strobe_a(data_strobe_a), .data_strobe_b(data_strobe_b),
        .port_chip_select_n(port_chip_select_n), .addr_latch_n(addr_latch_n),
        .register_select(register_select), .read_write_select(read_write_select),
        .halfword_select(halfword_select), .host_data_in(host_data_in));

    // Aux channel stand-in; read data is scrambled whenever no answer is given
    always @(negedge sys_clk) begin
        if (sys_rst) begin
            dma_ack <= 1'b0;
            dma_rdata <= 32'h0000_0000;
            wait_cnt <= 0;
        end else begin
            dma_ack <= 1'b0;
            dma_rdata <= ~dma_rdata;
            if (dma_req === 1'b1 && !dma_ack) begin
                if (wait_cnt < dma_lat) begin
                    wait_cnt <= wait_cnt + 1;
                end else begin
                    wait_cnt <= 0;
                    dma_ack <= 1'b1;
                    if (dma_write) mem[dma_addr] = dma_wdata;
                    else dma_rdata <= mem.exists(dma_addr) ? mem[dma_addr] : 32'h0;
                end
            end
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly one thousand cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end

    // Expected half of a word, following the order bit of control
    function automatic logic [15:0] part(input logic [31:0] w, input logic h);
        return (h ^ order) ? w[31:16] : w[15:0];
    endfunction

    // One access with the bus checks every access shares
    task automatic acc(input logic [1:0] s, input logic rw, input logic h, input logic ka,
                       input logic [15:0] wd);
        hpc_host_model_inst.access(s, rw, h, use_as, ka, 1'($random(seed)), wd);
        check("oe during", {31'h0, hpc_host_model_inst.oe_mid}, {31'h0, ~rw});
        check("oe after", {31'h0, hpc_host_model_inst.oe_end}, 32'h1); // Bus released
        if (!ka) check("ready deselected", {31'h0, hpc_host_model_inst.rdy_end}, 32'h0);
    endtask

    task automatic wr32(input logic [1:0] s, input logic [31:0] w, input logic ka);
        acc(s, 1'b0, 1'b0, 1'b1, part(w, 1'b0));
        check("ready first half", {31'h0, hpc_host_model_inst.rdy_after}, 32'h0);
        acc(s, 1'b0, 1'b1, ka, part(w, 1'b1));
        if (ka) check("ready after write",
                      {31'h0, hpc_host_model_inst.rdy_after}, {31'h0, s[0]});
    endtask

    task automatic rd32(input logic [1:0] s, input logic [31:0] w);
        acc(s, 1'b1, 1'b0, 1'b1, 16'h0000);
        check("busy on fetch", {31'h0, hpc_host_model_inst.busy_mid}, 32'h1);
        check("read low", {16'h0, hpc_host_model_inst.rd_val},
              {16'h0, part(w, 1'b0)});
        acc(s, 1'b1, 1'b1, 1'b1, 16'h0000);
        check("read high", {16'h0, hpc_host_model_inst.rd_val}, {16'h0, part(w, 1'b1)});
        check("ready after read", {31'h0, hpc_host_model_inst.rdy_after},
              {31'h0, s == HPC_SEL_DATA_INC}); // Busy only after autoincrement
    endtask

    // Main sequence: reset, ghost strobe, random register round trips, busy at select
    initial begin
        sys_rst = 1'b1;
        {errors, checks_done, cycles, dma_lat} = '0;
        {order, use_as} = 2'h0;
        seed = 30;
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        check("reset ready", {31'h0, port_ready_n}, 32'h0);
        check("reset oe", {31'h0, host_data_oe_n}, 32'h1);
        hpc_host_model_inst.ghost();
        check("ghost oe", {31'h0, hpc_host_model_inst.oe_mid}, 32'h1); // Deselected strobe
        check("ghost req", {31'h0, dma_req}, 32'h0); // No fetch when deselected
        for (int it = 0; it < 8; it++) begin
            order = 1'($random(seed));
            use_as = (it < 2) ? 1'(it) : 1'($random(seed));
            dma_lat = $random(seed) & 7;
            a = $random(seed) & 32'h0000_fffc;
            x = (it == 0) ? 32'hffff_0000 : $random(seed);
            y = (it == 0) ? 32'h0000_ffff : $random(seed);
            acc(HPC_SEL_CTRL, 1'b0, 1'b0, 1'b1, {15'h0, order});
            check("ready ctrl", {31'h0, hpc_host_model_inst.rdy_after}, 32'h0);
            acc(HPC_SEL_CTRL, 1'b1, 1'b0, 1'b1, 16'h0000);
            check("ctrl read", {16'h0, hpc_host_model_inst.rd_val}, {31'h0, order});
            check("ctrl busy", {31'h0, hpc_host_model_inst.busy_mid}, 32'h0);
            wr32(HPC_SEL_ADDR, a, 1'b1);
            wr32(HPC_SEL_DATA_INC, x, 1'b1);
            wr32(HPC_SEL_DATA_INC, y, 1'b0);
            wr32(HPC_SEL_ADDR, a, 1'b1);
            rd32(HPC_SEL_DATA_INC, x);
            rd32(HPC_SEL_DATA, y);
            check("store first", mem[a], x); // Write data taken at strobe rise
            check("store next", mem[a + 32'h4], y);
        end
        dma_lat = 12;
        wr32(HPC_SEL_DATA, x, 1'b0);
        acc(HPC_SEL_CTRL, 1'b1, 1'b0, 1'b1, 16'h0000);
        check("busy at select", {31'h0, hpc_host_model_inst.busy_cs}, 32'h1);
        check("host hang", {31'h0, hpc_host_model_inst.hung}, 32'h0);
        close_out();
    end
endmodule // tb_hpc_host_port
`default_nettype wire
